// ### ducrm_pkg.sv
// constants and types shared by the channel register map
package ducrm_pkg;
    // register offsets on the three address lines
    localparam logic [2:0] OFF_HOLD = 3'h0;
    localparam logic [2:0] OFF_IER = 3'h1;
    localparam logic [2:0] OFF_ISR = 3'h2;
    localparam logic [2:0] OFF_LCR = 3'h3;
    localparam logic [2:0] OFF_MCR = 3'h4;
    localparam logic [2:0] OFF_LSR = 3'h5;
    localparam logic [2:0] OFF_MSR = 3'h6;
    localparam logic [2:0] OFF_SCR = 3'h7;
    // line control value that opens the enhanced bank
    localparam logic [7:0] LCR_ENH_KEY = 8'hbf;
    localparam int LCR_DIV_BIT = 7;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // masks of the bits alive while the enhanced-enable bit is 0, and the full mask used while it is 1
    localparam logic [7:0] IER_BASE_MASK = 8'h0f;
    localparam logic [7:0] FCR_BASE_MASK = 8'hcf;
    localparam logic [7:0] MCR_BASE_MASK = 8'h1f;
    localparam logic [5:0] ISR_BASE_MASK = 6'h0f;
    localparam logic [7:0] AFR_USED_MASK = 8'h07;
    localparam logic [7:0] FULL_MASK = 8'hff;
    // field positions
    localparam int FCR_FIFO_EN = 0;
    localparam int FCR_RX_RST = 1;
    localparam int FCR_TX_RST = 2;
    localparam int FCR_DMA = 3;
    localparam int FCR_TRIG_LO = 6;
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_OP1 = 2;
    localparam int MCR_OP2 = 3;
    localparam int MCR_LOOP = 4;
    localparam int MCR_PRESCALE = 7;
    localparam int AFR_CONCURRENT = 0;
    localparam int AFR_BAUD_SEL = 1;
    localparam int AFR_RECEIVE_READY_PIN_SEL = 2;
    localparam int EFR_ENH_EN = 4;
    // prescaler applied when the prescaler select bit and the enhanced-enable bit are both set
    localparam logic [1:0] PRESCALE_LAST = 2'h3;
    localparam logic [15:0] DIV_ONE = 16'h0001;
    localparam logic [15:0] DIV_ZERO = 16'h0000;
    // which bank the address lines reach
    typedef enum logic [1:0] {
        BANK_NORMAL = 2'b00,
        BANK_DIVISOR = 2'b01,
        BANK_ENHANCED = 2'b11
    } ducrm_bank_e;
    // bank decode from the line control value
    function automatic ducrm_bank_e bankOf(input logic [7:0] line_control);
        if (line_control == LCR_ENH_KEY) begin
            return BANK_ENHANCED;
        end else if (line_control[LCR_DIV_BIT]) begin
            return BANK_DIVISOR;
        end
        return BANK_NORMAL;
    endfunction
endpackage

// ### ducrm_core_if.sv
// signals between the register map and its two helpers
`timescale 1ns/10ps
interface ducrm_core_if;
    logic [15:0] divisor;
    logic prescaleSel;
    logic baudTick;
    logic [3:0] modemLevels;
    logic deltaClear;
    logic [3:0] deltaFlags;
    modport rate (input divisor, input prescaleSel, output baudTick);
    modport watch (input modemLevels, input deltaClear,
                   output deltaFlags);
    modport hub (output divisor, output prescaleSel, output modemLevels,
                 output deltaClear, input baudTick, input deltaFlags);
endinterface

// ### ducrm_rate_counter.sv
// sixteen-bit rate counter with optional prescaler
`timescale 1ns/10ps
module ducrm_rate_counter
    import ducrm_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    ducrm_core_if.rate link
);
    typedef struct packed {
        logic [1:0] pre;
        logic [15:0] count;
        logic tick;
    } ducrm_rate_s;
    ducrm_rate_s st_q, st_d;
    logic preEn;

    // a zero divisor parks the counter, so no tick ever leaves it
    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        preEn = !link.prescaleSel || (st_q.pre == PRESCALE_LAST);
        st_d.pre = preEn ? 2'h0 : st_q.pre + 2'h1;
        if (link.divisor == DIV_ZERO) begin
            st_d.count = DIV_ZERO;
        end else if (preEn) begin
            if (st_q.count <= DIV_ONE) begin
                st_d.count = link.divisor;
                st_d.tick = 1'b1;
            end else begin
                st_d.count = st_q.count - DIV_ONE;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign link.baudTick = st_q.tick;

    a_tick_divisor: assert property (@(posedge core_clk) disable iff
        (!reset_n) st_q.tick |-> $past(link.divisor) != DIV_ZERO)
        else $error("rate tick with zero divisor");
endmodule

// ### ducrm_modem_watch.sv
// change detector for the four modem status inputs
`timescale 1ns/10ps
module ducrm_modem_watch
    import ducrm_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    ducrm_core_if.watch link
);
    typedef struct packed {
        logic primed;
        logic [3:0] prev;
        logic [3:0] delta;
    } ducrm_watch_s;
    ducrm_watch_s st_q, st_d;
    logic [3:0] change;

    // first sample after reset only primes, so reset is not a change
    always_comb begin
        st_d = st_q;
        change = st_q.primed ? (link.modemLevels ^ st_q.prev) : 4'h0;
        st_d.primed = 1'b1;
        st_d.prev = link.modemLevels;
        // a change in the clearing cycle still sets its flag
        st_d.delta = (st_q.delta & ~{4{link.deltaClear}}) | change;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign link.deltaFlags = st_q.delta;

    a_delta_sets: assert property (@(posedge core_clk) disable iff
        (!reset_n) (change != 4'h0) |=> ((st_q.delta & $past(change))
        == $past(change)))
        else $error("modem change lost");
endmodule

// ### ducrm_top.sv
// register map and address decode of one serial channel
`timescale 1ns/10ps
module ducrm_top
    import ducrm_pkg::*;
#(
    parameter logic [7:0] REVISION_CODE = 8'h5a, // arbitrary value
    parameter logic [7:0] PART_ID = 8'hc3 // arbitrary value
)(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [2:0] hostAddr,
    input wire logic [7:0] hostWrData,
    input wire logic hostWrStrobe,
    input wire logic hostRdStrobe,
    output logic [7:0] hostRdData,
    input wire logic [7:0] rxData,
    output logic rxDataPop,
    output logic [7:0] txData,
    output logic txDataPush,
    input wire logic [7:0] lineStatus,
    output logic lineStatusRead,
    input wire logic [5:0] intSource,
    output logic isrRead,
    input wire logic ctsIn,
    input wire logic dsrIn,
    input wire logic ringIn,
    input wire logic carrierDetectIn,
    input wire logic rxReadyN,
    output logic [7:0] lineControl,
    output logic [7:0] intEnable,
    output logic [7:0] modemControl,
    output logic [7:0] enhancedFeature,
    output logic [7:0] resumeCharFirst,
    output logic [7:0] resumeCharSecond,
    output logic [7:0] pauseCharFirst,
    output logic [7:0] pauseCharSecond,
    output logic fifoEnable,
    output logic rxFifoReset,
    output logic txFifoReset,
    output logic dmaMode,
    output logic [1:0] rxTrigger,
    output logic concurrentWrite,
    output logic baudTick,
    output logic sharedPinOut,
    output logic dtrOutN,
    output logic rtsOutN,
    output logic generalOutputTwoN,
    input wire logic txSerialIn,
    input wire logic rxSerialPin,
    output logic txSerialPin,
    output logic rxSerialOut
);
    typedef struct packed {
        logic [7:0] line_control;
        logic [7:0] interrupt_enable;
        logic [7:0] fifo_control;
        logic [7:0] modem_control;
        logic [7:0] scratch;
        logic [7:0] dll;
        logic [7:0] divisor_high;
        logic [7:0] alternate_function;
        logic [7:0] enhanced_feature;
        logic [7:0] resume_char_first;
        logic [7:0] resume_char_second;
        logic [7:0] pause_char_first;
        logic [7:0] pause_char_second;
        logic [7:0] rdData;
        logic [7:0] txData;
        logic txPush;
        logic rxPop;
        logic lsrRead;
        logic isrRead;
        logic rxFifoRst;
        logic txFifoRst;
        logic sharedPin;
    } ducrm_regs_s;
    ducrm_regs_s st_q, st_d;

    ducrm_core_if core ();
    ducrm_bank_e bank;
    logic enh;
    logic idMode;
    logic loop;
    logic msrRead;
    logic [7:0] ierMask;
    logic [7:0] mcrMask;
    logic [7:0] fcrMask;
    logic [5:0] isrMask;
    logic [3:0] levels;
    logic [7:0] msrByte;
    logic [7:0] isrByte;

    ducrm_rate_counter u_rate (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .link(core.rate)
    );

    ducrm_modem_watch u_watch (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .link(core.watch)
    );

    // decode and gating terms shared by the read and write paths
    assign bank = bankOf(st_q.line_control);
    assign enh = st_q.enhanced_feature[EFR_ENH_EN];
    assign idMode = (bank == BANK_DIVISOR) && (st_q.dll == RESET_BYTE)
                    && (st_q.divisor_high == RESET_BYTE);
    assign loop = st_q.modem_control[MCR_LOOP];
    // stored IER and MCR extended bits survive, but are masked while disabled; FCR ones are dropped on write
    assign ierMask = enh ? FULL_MASK : IER_BASE_MASK;
    assign mcrMask = enh ? FULL_MASK : MCR_BASE_MASK;
    assign fcrMask = enh ? FULL_MASK : FCR_BASE_MASK;
    assign isrMask = enh ? 6'h3f : ISR_BASE_MASK;
    // loopback replaces the modem inputs with the modem outputs
    assign levels = loop ? {st_q.modem_control[MCR_OP2], st_q.modem_control[MCR_OP1],
                            st_q.modem_control[MCR_DTR], st_q.modem_control[MCR_RTS]}
                         : {carrierDetectIn, ringIn, dsrIn, ctsIn};
    assign msrByte = {levels, core.deltaFlags};
    assign isrByte = {{2{st_q.fifo_control[FCR_FIFO_EN]}},
                      intSource & isrMask};
    assign msrRead = hostRdStrobe && (hostAddr == OFF_MSR)
                     && (bank != BANK_ENHANCED);
    assign core.divisor = {st_q.divisor_high, st_q.dll};
    assign core.prescaleSel = st_q.modem_control[MCR_PRESCALE] && enh;
    assign core.modemLevels = levels;
    assign core.deltaClear = msrRead;

    // host write, host read and their side effects
    always_comb begin
        st_d = st_q;
        st_d.txPush = 1'b0;
        st_d.rxPop = 1'b0;
        st_d.lsrRead = 1'b0;
        st_d.isrRead = 1'b0;
        st_d.rxFifoRst = 1'b0;
        st_d.txFifoRst = 1'b0;
        if (hostWrStrobe) begin
            case (hostAddr)
                OFF_HOLD: begin
                    if (bank == BANK_NORMAL) begin
                        st_d.txData = hostWrData;
                        st_d.txPush = 1'b1;
                    end else begin
                        st_d.dll = hostWrData;
                    end
                end
                OFF_IER: begin
                    if (bank == BANK_NORMAL) begin
                        st_d.interrupt_enable = hostWrData;
                    end else begin
                        st_d.divisor_high = hostWrData;
                    end
                end
                OFF_ISR: begin
                    case (bank)
                        BANK_NORMAL: begin
                            st_d.fifo_control = hostWrData & fcrMask;
                            st_d.rxFifoRst = hostWrData[FCR_RX_RST];
                            st_d.txFifoRst = hostWrData[FCR_TX_RST];
                        end
                        BANK_DIVISOR: begin
                            st_d.alternate_function = hostWrData & AFR_USED_MASK;
                        end
                        default: begin
                            st_d.enhanced_feature = hostWrData;
                        end
                    endcase
                end
                OFF_LCR: begin
                    st_d.line_control = hostWrData;
                end
                OFF_MCR: begin
                    if (bank == BANK_ENHANCED) begin
                        st_d.resume_char_first = hostWrData;
                    end else begin
                        st_d.modem_control = hostWrData;
                    end
                end
                OFF_LSR: begin
                    if (bank == BANK_ENHANCED) begin
                        st_d.resume_char_second = hostWrData;
                    end
                end
                OFF_MSR: begin
                    if (bank == BANK_ENHANCED) begin
                        st_d.pause_char_first = hostWrData;
                    end
                end
                default: begin
                    if (bank == BANK_ENHANCED) begin
                        st_d.pause_char_second = hostWrData;
                    end else begin
                        st_d.scratch = hostWrData;
                    end
                end
            endcase
        end
        if (hostRdStrobe) begin
            case (hostAddr)
                OFF_HOLD: begin
                    if (bank == BANK_NORMAL) begin
                        st_d.rdData = rxData;
                        st_d.rxPop = 1'b1;
                    end else begin
                        st_d.rdData = idMode ? REVISION_CODE
                                             : st_q.dll;
                    end
                end
                OFF_IER: begin
                    if (bank == BANK_NORMAL) begin
                        st_d.rdData = st_q.interrupt_enable & ierMask;
                    end else begin
                        st_d.rdData = idMode ? PART_ID : st_q.divisor_high;
                    end
                end
                OFF_ISR: begin
                    case (bank)
                        BANK_NORMAL: begin
                            st_d.rdData = isrByte;
                            st_d.isrRead = 1'b1;
                        end
                        BANK_DIVISOR: begin
                            st_d.rdData = st_q.alternate_function;
                        end
                        default: begin
                            st_d.rdData = st_q.enhanced_feature;
                        end
                    endcase
                end
                OFF_LCR: begin
                    st_d.rdData = st_q.line_control;
                end
                OFF_MCR: begin
                    st_d.rdData = (bank == BANK_ENHANCED) ? st_q.resume_char_first
                                  : st_q.modem_control & mcrMask;
                end
                OFF_LSR: begin
                    if (bank == BANK_ENHANCED) begin
                        st_d.rdData = st_q.resume_char_second;
                    end else begin
                        st_d.rdData = lineStatus;
                        st_d.lsrRead = 1'b1;
                    end
                end
                OFF_MSR: begin
                    st_d.rdData = (bank == BANK_ENHANCED) ? st_q.pause_char_first
                                  : msrByte;
                end
                default: begin
                    st_d.rdData = (bank == BANK_ENHANCED) ? st_q.pause_char_second
                                  : st_q.scratch;
                end
            endcase
        end
        // shared pin: receive-ready wins over the rate output
        if (st_q.alternate_function[AFR_RECEIVE_READY_PIN_SEL]) begin
            st_d.sharedPin = rxReadyN;
        end else if (st_q.alternate_function[AFR_BAUD_SEL]) begin
            st_d.sharedPin = !core.baudTick;
        end else begin
            st_d.sharedPin = !st_q.modem_control[MCR_OP2];
        end
    end

    // all control state starts cleared, divisor zero included
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the registers, extended bits gated
    assign hostRdData = st_q.rdData;
    assign rxDataPop = st_q.rxPop;
    assign txData = st_q.txData;
    assign txDataPush = st_q.txPush;
    assign lineStatusRead = st_q.lsrRead;
    assign isrRead = st_q.isrRead;
    assign lineControl = st_q.line_control;
    assign intEnable = st_q.interrupt_enable & ierMask;
    assign modemControl = st_q.modem_control & mcrMask;
    assign enhancedFeature = st_q.enhanced_feature;
    assign resumeCharFirst = st_q.resume_char_first;
    assign resumeCharSecond = st_q.resume_char_second;
    assign pauseCharFirst = st_q.pause_char_first;
    assign pauseCharSecond = st_q.pause_char_second;
    assign fifoEnable = st_q.fifo_control[FCR_FIFO_EN];
    assign rxFifoReset = st_q.rxFifoRst;
    assign txFifoReset = st_q.txFifoRst;
    assign dmaMode = st_q.fifo_control[FCR_DMA];
    assign rxTrigger = st_q.fifo_control[FCR_TRIG_LO +: 2];
    assign concurrentWrite = st_q.alternate_function[AFR_CONCURRENT];
    assign baudTick = core.baudTick;
    assign sharedPinOut = st_q.sharedPin;
    // loopback holds dtrOutN, rtsOutN and generalOutputTwoN deasserted and the line marking, but not the shared pin
    assign dtrOutN = loop || !st_q.modem_control[MCR_DTR];
    assign rtsOutN = loop || !st_q.modem_control[MCR_RTS];
    assign generalOutputTwoN = loop || !st_q.modem_control[MCR_OP2];
    assign txSerialPin = loop || txSerialIn;
    assign rxSerialOut = loop ? txSerialIn : rxSerialPin;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_hold_read: assert property (hostRdStrobe && hostAddr == OFF_HOLD
        && bank == BANK_NORMAL |=> rxDataPop
        && hostRdData == $past(rxData))
        else $error("receive byte not returned");
    a_hold_write: assert property (hostWrStrobe && hostAddr == OFF_HOLD
        && bank == BANK_NORMAL |=> txDataPush
        && txData == $past(hostWrData))
        else $error("transmit byte not pushed");
    a_divisor_bank: assert property (hostWrStrobe && hostAddr == OFF_IER
        && bank == BANK_DIVISOR |=> st_q.divisor_high == $past(hostWrData)
        && intEnable == $past(intEnable))
        else $error("divisor high write misrouted");
    a_enhanced_bank: assert property (hostWrStrobe && hostAddr == OFF_ISR
        && st_q.line_control == LCR_ENH_KEY |=> st_q.enhanced_feature == $past(hostWrData)
        && !rxFifoReset)
        else $error("enhanced feature write misrouted");
    a_ext_gate: assert property (!enhancedFeature[EFR_ENH_EN] |->
        intEnable[7:4] == 4'h0 && modemControl[7:5] == 3'h0)
        else $error("extended bits leak while disabled");
    a_ident_read: assert property (hostRdStrobe && hostAddr == OFF_IER
        && idMode |=> hostRdData == PART_ID)
        else $error("part identifier not returned");
    a_isr_fifo: assert property (hostRdStrobe && hostAddr == OFF_ISR
        && bank == BANK_NORMAL |=> isrRead
        && hostRdData[7:6] == {2{$past(fifoEnable)}}
        && hostRdData[3:0] == $past(intSource[3:0]))
        else $error("interrupt status read wrong");
    a_scratch_echo: assert property (hostWrStrobe && hostAddr == OFF_SCR
        && bank == BANK_NORMAL ##1 !hostWrStrobe ##1 hostRdStrobe
        && !hostWrStrobe && hostAddr == OFF_SCR && bank == BANK_NORMAL
        |=> hostRdData == $past(hostWrData, 3))
        else $error("scratch value changed");
    a_afr_reserved: assert property (st_q.alternate_function[7:3] == 5'h00)
        else $error("alternate function reserved bits set");
    a_loop_route: assert property (modemControl[MCR_LOOP] |->
        rxSerialOut == txSerialIn && txSerialPin)
        else $error("loopback not routed");

    c_tx_push: cover property (txDataPush);
    c_ident_mode: cover property (hostRdStrobe && idMode);
    c_enh_write: cover property (hostWrStrobe && bank == BANK_ENHANCED);
    c_loopback: cover property (loop && txSerialIn != rxSerialPin);
endmodule

// ### ducrm_host_model.sv
// host-side bus model issuing register accesses
`timescale 1ns/10ps
module ducrm_host_model (
    input wire logic core_clk,
    output logic [2:0] hostAddr,
    output logic [7:0] hostWrData,
    output logic hostWrStrobe,
    output logic hostRdStrobe,
    input wire logic [7:0] hostRdData
);
    initial begin
        hostAddr = 3'h0;
        hostWrData = 8'h00;
        hostWrStrobe = 1'b0;
        hostRdStrobe = 1'b0;
    end
    // one-cycle strobe; address and data held over the taking edge
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge core_clk);
        hostAddr <= a;
        hostWrData <= v;
        hostWrStrobe <= 1'b1;
        @(posedge core_clk);
        hostWrStrobe <= 1'b0;
        hostWrData <= ~v; // released data must not keep its value
    endtask
    // read byte is taken 1 ns after the taking edge
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge core_clk);
        hostAddr <= a;
        hostRdStrobe <= 1'b1;
        @(posedge core_clk);
        hostRdStrobe <= 1'b0;
        #1 v = hostRdData;
    endtask
endmodule

// ### tb.sv
// self-checking bench for the channel register map
`timescale 1ns/10ps
module tb;
    import ducrm_pkg::*;
    localparam logic [7:0] REV = 8'h5a; // arbitrary value
    localparam logic [7:0] PID = 8'hc3; // arbitrary value
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] hostAddr;
    logic [7:0] hostWrData, hostRdData, txData, d, e;
    logic hostWrStrobe, hostRdStrobe, rxDataPop, txDataPush;
    logic [7:0] rxData = 8'h00;
    logic [7:0] lineStatus = 8'h00;
    logic [5:0] intSource = 6'h00;
    logic [3:0] mdm = 4'h0; // carrier, ring, set-ready, clear-to-send
    logic rxReadyN = 1'b1;
    logic rxSerialPin = 1'b1;
    logic txSerialIn = 1'b1;
    logic [7:0] sq[$];
    logic [7:0] lcrOut, ierOut, mcrOut, efrOut;
    logic [31:0] fc; // flow characters, offset 4 in the low byte
    logic [5:0] fo; // fifo enable, trigger, dma, tx and rx reset
    logic [2:0] mo; // active-low terminal-ready, send request, output two
    logic lsrRd, isrRd, cwr, tick, shPin, txPin, rxOut;
    int n;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    always #10 core_clk = ~core_clk;
    ducrm_host_model ducrm_host_model_inst (.core_clk(core_clk),
        .hostAddr(hostAddr), .hostWrData(hostWrData),
        .hostWrStrobe(hostWrStrobe), .hostRdStrobe(hostRdStrobe),
        .hostRdData(hostRdData));
    ducrm_top #(.REVISION_CODE(REV), .PART_ID(PID)) ducrm_top_inst (
        .core_clk(core_clk), .reset_n(reset_n), .hostAddr(hostAddr),
        .hostWrData(hostWrData), .hostWrStrobe(hostWrStrobe),
        .hostRdStrobe(hostRdStrobe), .hostRdData(hostRdData),
        .rxData(rxData), .rxDataPop(rxDataPop), .txData(txData),
        .txDataPush(txDataPush), .lineStatus(lineStatus),
        .lineStatusRead(lsrRd), .intSource(intSource), .isrRead(isrRd),
        .ctsIn(mdm[0]), .dsrIn(mdm[1]), .ringIn(mdm[2]),
        .carrierDetectIn(mdm[3]), .rxReadyN(rxReadyN),
        .lineControl(lcrOut), .intEnable(ierOut), .modemControl(mcrOut),
        .enhancedFeature(efrOut), .resumeCharFirst(fc[7:0]),
        .resumeCharSecond(fc[15:8]), .pauseCharFirst(fc[23:16]),
        .pauseCharSecond(fc[31:24]), .fifoEnable(fo[5]),
        .rxFifoReset(fo[0]), .txFifoReset(fo[1]), .dmaMode(fo[2]),
        .rxTrigger(fo[4:3]), .concurrentWrite(cwr), .baudTick(tick),
        .sharedPinOut(shPin), .dtrOutN(mo[2]), .rtsOutN(mo[1]),
        .generalOutputTwoN(mo[0]), .txSerialIn(txSerialIn),
        .rxSerialPin(rxSerialPin), .txSerialPin(txPin),
        .rxSerialOut(rxOut));
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        ducrm_host_model_inst.wr(a, v);
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        ducrm_host_model_inst.rd(a, v);
    endtask
    // compare and count; mismatches reported at once
    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        samples_checked++;
        if (g !== x) begin
            error_cnt++;
            $display("[FAIL] %0t got %h want %h", $time, g, x);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // cut a hang short; the sequence needs well under 1000 cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(32'h3e45));
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        // scratch round trips, values queued by the bench
        for (int i = 0; i < 4; i++) begin
            sq.push_back(8'($urandom));
            wr(OFF_SCR, sq[$]);
            rd(OFF_SCR, d);
            chk(d, sq.pop_front());
        end
        $display("test scratch done");
        @(posedge core_clk);
        rxData <= 8'($urandom);
        rd(OFF_HOLD, d);
        chk(d, rxData);
        chk({7'h0, rxDataPop}, 8'h01);
        e = 8'($urandom);
        wr(OFF_HOLD, e);
        #1 chk(txData, e);
        chk({7'h0, txDataPush}, 8'h01);
        $display("test holding done");
        @(posedge core_clk);
        lineStatus <= 8'($urandom);
        mdm <= 4'($urandom);
        repeat (4) @(posedge core_clk);
        rd(OFF_LSR, d);
        chk(d, lineStatus);
        chk({7'h0, lsrRd}, 8'h01);
        rd(OFF_MSR, d);
        chk(d, {mdm, mdm});
        rd(OFF_MSR, d);
        chk(d, {mdm, 4'h0});
        wr(OFF_ISR, 8'hcf);
        intSource <= 6'($urandom);
        #1 chk({2'h0, fo}, 8'h3f);
        rd(OFF_ISR, d);
        chk(d, {4'hc, intSource[3:0]});
        chk({7'h0, isrRd}, 8'h01);
        $display("test status done");
        // zero divisor shows identity, then divisor and alt function
        wr(OFF_LCR, 8'h83);
        rd(OFF_HOLD, d);
        chk(d, REV);
        chk(lcrOut, 8'h83);
        rd(OFF_IER, d);
        chk(d, PID);
        e = 8'($urandom) | 8'h01;
        wr(OFF_HOLD, e);
        rd(OFF_HOLD, d);
        chk(d, e);
        // ticks come once every divisor cycles with the prescaler off
        @(negedge core_clk);
        while (!tick) @(negedge core_clk);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (!tick);
        chk(8'(n), e);
        @(posedge core_clk);
        rxReadyN <= 1'b0;
        wr(OFF_ISR, 8'hff);
        rd(OFF_ISR, d);
        chk(d, 8'h07);
        chk({6'h0, shPin, cwr}, 8'h01);
        $display("test divisor bank done");
        // enhanced bank, then extended bits with and without enable
        wr(OFF_LCR, LCR_ENH_KEY);
        wr(OFF_ISR, 8'h10);
        rd(OFF_ISR, d);
        chk(d, 8'h10);
        chk(efrOut, 8'h10);
        for (int a = 4; a < 8; a++) begin
            sq.push_back(8'($urandom));
            wr(3'(a), sq[$]);
        end
        for (int a = 4; a < 8; a++) begin
            rd(3'(a), d);
            e = sq.pop_front();
            chk(d, e);
            chk(fc[8*(a-4) +: 8], e);
        end
        wr(OFF_LCR, 8'h03);
        wr(OFF_IER, 8'hff);
        rd(OFF_IER, d);
        chk(d, 8'hff);
        chk(ierOut, 8'hff);
        rd(OFF_LCR, d);
        chk(d, 8'h03);
        wr(OFF_LCR, LCR_ENH_KEY);
        wr(OFF_ISR, 8'h00);
        wr(OFF_LCR, 8'h03);
        rd(OFF_IER, d);
        chk(d, 8'h0f);
        chk(ierOut, 8'h0f);
        $display("test enhanced bank done");
        // modem outputs, then loopback with extended bits masked
        wr(OFF_MCR, 8'h0b);
        #1 chk({5'h0, mo}, 8'h00);
        @(posedge core_clk);
        txSerialIn <= 1'b0;
        wr(OFF_MCR, 8'hfb);
        #1 chk(mcrOut, 8'h1b);
        chk({3'h0, mo, txPin, rxOut}, 8'h1e);
        rd(OFF_MSR, d);
        chk({4'h0, d[7:4]}, 8'h0b);
        $display("test modem done");
        complete_run();
    end
endmodule
